// >>> design/dlc_defs.svh
`ifndef DLC_DEFS_SVH
`define DLC_DEFS_SVH

// Register byte offsets
`define DLC_OFF_STATUS 12'h280
`define DLC_OFF_ADDR   12'h288
`define DLC_OFF_COUNT  12'h298
`define DLC_OFF_LOC    12'h2A0
`define DLC_OFF_ISTAT  12'h2B0
`define DLC_OFF_IMASK  12'h2B8
`define DLC_OFF_DBG    12'h2C0

// Widths
`define DLC_BUS_AW   12
`define DLC_BUS_DW   64
`define DLC_SYND_W   16
`define DLC_ADDR_W   36
`define DLC_LOC_W    36
`define DLC_NIB_W    6
`define DLC_CNT_W    16
`define DLC_STAT_W   7
`define DLC_IRQ_W    3

// Status register fields
`define DLC_STAT_HI  63
`define DLC_STAT_LO  57
`define DLC_SYND_HI  15
`define DLC_S_MEU    6
`define DLC_S_MEC    5
`define DLC_S_DAC    4
`define DLC_S_DAU    3
`define DLC_S_DSC    2
`define DLC_S_DSU    1
`define DLC_S_DBU    0
`define DLC_STAT_PAD 41'h0

// Error address field
`define DLC_ADDR_HI  39
`define DLC_ADDR_LO  4

// Counter register fields
`define DLC_CNT_ENB   17
`define DLC_CNT_VALID 16
`define DLC_CNT_HI    15
`define DLC_CNT_ONE   16'h0001
`define DLC_CNT_ZERO  16'h0000

// Location register
`define DLC_LOC_HI   35
`define DLC_LOC_ONE  36'h0_0000_0001

// Interrupt status / mask bits
`define DLC_I_CNT    0
`define DLC_I_UE     1
`define DLC_I_CE     2
`define DLC_IRQ_HI   2

// Debug control bits
`define DLC_DBG_EN   0
`define DLC_DBG_STOP 1

`endif

// >>> design/dlc_pkg.sv
`include "dlc_defs.svh"

package dlc_pkg;

    typedef struct packed {
        logic                    wr;
        logic                    rd;
        logic [`DLC_BUS_AW-1:0]  addr;
        logic [`DLC_BUS_DW-1:0]  wdata;
    } dlc_bus_t;

    typedef struct packed {
        logic                    dac;
        logic                    dau;
        logic                    dsc;
        logic                    dsu;
        logic                    dbu;
        logic [`DLC_SYND_W-1:0]  synd;
        logic [`DLC_ADDR_W-1:0]  addr;
        logic [`DLC_NIB_W-1:0]   nibble;
    } dlc_err_t;

    typedef struct packed {
        logic [`DLC_STAT_W-1:0]  stat;
        logic [`DLC_SYND_W-1:0]  synd;
        logic [`DLC_ADDR_W-1:0]  errAddr;
        logic                    cntEnb;
        logic                    cntValid;
        logic [`DLC_CNT_W-1:0]   count;
        logic [`DLC_LOC_W-1:0]   location;
        logic [`DLC_IRQ_W-1:0]   intStat;
        logic [`DLC_IRQ_W-1:0]   intMask;
        logic                    dbgEn;
        logic                    clkStopSel;
        logic                    intMgmt;
        logic                    trigStop;
        logic                    trigPin;
        logic [`DLC_BUS_DW-1:0]  rdData;
    } dlc_state_t;

endpackage

// >>> design/dlc_error_log.sv
`timescale 1ns/1ps
`include "dlc_defs.svh"

// Function
// - Scrub error physical address 39:4 is captured in the address register.
// - Address, counter and location logs survive reset; reserved bits read 0.
// - Error address update wins over a same-cycle software write.
// - While valid, each correctable 16-byte chunk decrements count by one.
// - Count reaching zero with enable and valid pulses management line.
// - Valid bit clears itself when count decrements to zero.
// - Enable bit 17, valid bit 16 and count are software read/write.
// - Uncorrectable errors never decrement, pulse management line or trigger.
// - Debug trigger: enable set, count loaded with 1; select stop or pin.
// - Each correctable error loads a one-hot bad-nibble location.
// - Bits 35:32 check nibbles, 31 data 127:124, down to 0 data 3:0.
// - Correctable access error sets the access-correctable flag.
// - Uncorrectable access error sets access-uncorrectable flag, logs syndrome.
// - Nonexistent address sets out-of-bounds flag, not an ECC flag.
// - DMA errors use the ordinary access flags.
// - Flags clear only by writing one; hardware never clears them.
// - Mixed same-cycle errors: mec plus the uncorrectable flag and syndrome.
module dlc_error_log (
    input  wire logic                   core_clk,
    input  wire logic                   sys_rst,
    input  wire dlc_pkg::dlc_bus_t      bus,
    output logic [`DLC_BUS_DW-1:0]      rdData,
    input  wire dlc_pkg::dlc_err_t      err,
    output logic                        intMgmtLine,
    output logic                        trigClockStop,
    output logic                        trigErrPin,
    output logic                        irq
);
    import dlc_pkg::*;

    dlc_state_t st;
    dlc_state_t next_st;
    logic       ueNew;
    logic       ceNew;
    logic       oldUe;
    logic       oldCe;
    logic       wrStatus;
    logic       wrAddr;
    logic       wrCount;

    // Access flags already cover DMA reads and partial writes
    assign ueNew    = err.dau | err.dsu | err.dbu;
    assign ceNew    = err.dac | err.dsc;
    assign oldUe    = st.stat[`DLC_S_DAU] | st.stat[`DLC_S_DSU]
                    | st.stat[`DLC_S_DBU];
    assign oldCe    = st.stat[`DLC_S_DAC] | st.stat[`DLC_S_DSC];
    assign wrStatus = bus.wr && bus.addr == `DLC_OFF_STATUS;
    assign wrAddr   = bus.wr && bus.addr == `DLC_OFF_ADDR;
    assign wrCount  = bus.wr && bus.addr == `DLC_OFF_COUNT;

    always_comb begin
        next_st          = st;
        next_st.intMgmt  = 1'b0;
        next_st.trigStop = 1'b0;
        next_st.trigPin  = 1'b0;
        next_st.rdData   = '0;

        // Software writes act first; error updates below override them
        if (bus.wr) begin
            case (bus.addr)
                `DLC_OFF_STATUS: begin
                    next_st.stat = st.stat
                        & ~bus.wdata[`DLC_STAT_HI:`DLC_STAT_LO];
                    next_st.synd = bus.wdata[`DLC_SYND_HI:0];
                end
                `DLC_OFF_ADDR: begin
                    next_st.errAddr =
                        bus.wdata[`DLC_ADDR_HI:`DLC_ADDR_LO];
                end
                `DLC_OFF_COUNT: begin
                    next_st.cntEnb   = bus.wdata[`DLC_CNT_ENB];
                    next_st.cntValid = bus.wdata[`DLC_CNT_VALID];
                    next_st.count    = bus.wdata[`DLC_CNT_HI:0];
                end
                `DLC_OFF_LOC: begin
                    next_st.location = bus.wdata[`DLC_LOC_HI:0];
                end
                `DLC_OFF_ISTAT: begin
                    next_st.intStat = st.intStat
                        & ~bus.wdata[`DLC_IRQ_HI:0];
                end
                `DLC_OFF_IMASK: begin
                    next_st.intMask = bus.wdata[`DLC_IRQ_HI:0];
                end
                `DLC_OFF_DBG: begin
                    next_st.dbgEn      = bus.wdata[`DLC_DBG_EN];
                    next_st.clkStopSel = bus.wdata[`DLC_DBG_STOP];
                end
                default: begin
                end
            endcase
        end

        // Flag setting looks at the pre-write state so a clear in the
        // same cycle cannot hide what was already logged
        if (ueNew) begin
            if (oldUe) begin
                next_st.stat[`DLC_S_MEU] = 1'b1;
            end else begin
                next_st.stat[`DLC_S_DAU] =
                    next_st.stat[`DLC_S_DAU] | err.dau;
                next_st.stat[`DLC_S_DSU] =
                    next_st.stat[`DLC_S_DSU] | err.dsu;
                next_st.stat[`DLC_S_DBU] =
                    next_st.stat[`DLC_S_DBU] | err.dbu;
                next_st.synd = err.synd;
                if (err.dsu) begin
                    next_st.errAddr = err.addr;
                end
            end
            if (ceNew) begin
                next_st.stat[`DLC_S_MEC] = 1'b1;
            end
        end else if (ceNew) begin
            if (oldUe || oldCe) begin
                next_st.stat[`DLC_S_MEC] = 1'b1;
            end else begin
                next_st.stat[`DLC_S_DAC] =
                    next_st.stat[`DLC_S_DAC] | err.dac;
                next_st.stat[`DLC_S_DSC] =
                    next_st.stat[`DLC_S_DSC] | err.dsc;
                next_st.synd = err.synd;
                if (err.dsc) begin
                    next_st.errAddr = err.addr;
                end
            end
        end

        // Index 35..32 are check nibbles, 31..0 data nibbles
        if (ceNew) begin
            next_st.location = `DLC_LOC_ONE << err.nibble;
        end

        // Only correctable chunks count; a same-cycle write is counted
        // on, so the chunk is never lost
        if (ceNew && next_st.cntValid
                && next_st.count != `DLC_CNT_ZERO) begin
            next_st.count = next_st.count - `DLC_CNT_ONE;
            if (next_st.count == `DLC_CNT_ZERO) begin
                next_st.cntValid = 1'b0;
                if (next_st.cntEnb) begin
                    next_st.intMgmt = 1'b1;
                    next_st.intStat[`DLC_I_CNT] = 1'b1;
                end
                if (next_st.dbgEn) begin
                    next_st.trigStop = next_st.clkStopSel;
                    next_st.trigPin  = ~next_st.clkStopSel;
                end
            end
        end

        if (ueNew) begin
            next_st.intStat[`DLC_I_UE] = 1'b1;
        end
        if (ceNew) begin
            next_st.intStat[`DLC_I_CE] = 1'b1;
        end

        // Reserved bits read as zero
        if (bus.rd) begin
            case (bus.addr)
                `DLC_OFF_STATUS: next_st.rdData =
                    {st.stat, `DLC_STAT_PAD, st.synd};
                `DLC_OFF_ADDR: next_st.rdData =
                    {24'h0, st.errAddr, 4'h0};
                `DLC_OFF_COUNT: next_st.rdData =
                    {46'h0, st.cntEnb, st.cntValid, st.count};
                `DLC_OFF_LOC: next_st.rdData = {28'h0, st.location};
                `DLC_OFF_ISTAT: next_st.rdData = {61'h0, st.intStat};
                `DLC_OFF_IMASK: next_st.rdData = {61'h0, st.intMask};
                `DLC_OFF_DBG: next_st.rdData =
                    {62'h0, st.clkStopSel, st.dbgEn};
                default: next_st.rdData = '0;
            endcase
        end
    end

    // Logs are left out of reset so software can inspect them after an
    // error-induced reset; they start undefined at power-up
    always_ff @(posedge core_clk) begin
        st <= next_st;
        if (sys_rst) begin
            st.intStat    <= '0;
            st.intMask    <= '0;
            st.dbgEn      <= 1'b0;
            st.clkStopSel <= 1'b0;
            st.intMgmt    <= 1'b0;
            st.trigStop   <= 1'b0;
            st.trigPin    <= 1'b0;
            st.rdData     <= '0;
        end
    end

    assign rdData        = st.rdData;
    assign intMgmtLine   = st.intMgmt;
    assign trigClockStop = st.trigStop;
    assign trigErrPin    = st.trigPin;
    assign irq           = |(st.intStat & st.intMask);

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    sequence lastChunk;
        ceNew && st.cntValid && st.count == `DLC_CNT_ONE && !wrCount;
    endsequence

    sequence pulseOnce(sig);
        sig ##1 !sig;
    endsequence

    chk_addr_capture:
    assert property (err.dsu && !oldUe |=> st.errAddr == $past(err.addr))
        else $error("scrub address not captured");

    chk_addr_write_lose:
    assert property (wrAddr && err.dsc && !ueNew && !oldUe && !oldCe
                     |=> st.errAddr == $past(err.addr))
        else $error("software write beat error address");

    chk_count_dec:
    assert property (ceNew && st.cntValid && st.count > `DLC_CNT_ONE
                     && !wrCount
                     |=> st.count == $past(st.count) - `DLC_CNT_ONE)
        else $error("count did not decrement by one");

    chk_count_int:
    assert property (lastChunk ##0 st.cntEnb |=> pulseOnce(intMgmtLine))
        else $error("missing counter interrupt pulse");

    chk_valid_clear:
    assert property (lastChunk |=> !st.cntValid
                     && st.count == `DLC_CNT_ZERO)
        else $error("valid not cleared at zero");

    chk_ue_nocount:
    assert property (ueNew && !ceNew && !wrCount
                     |=> $stable(st.count) && !intMgmtLine
                     && !trigClockStop && !trigErrPin)
        else $error("uncorrectable error touched counter");

    chk_dbg_trig:
    assert property (lastChunk ##0 st.dbgEn
                     |=> (trigClockStop != trigErrPin)
                     && trigClockStop == $past(st.clkStopSel))
        else $error("debug trigger wrong or missing");

    chk_loc_onehot:
    assert property (ceNew |=> $onehot(st.location)
                     && st.location[$past(err.nibble)])
        else $error("location not one-hot at nibble");

    chk_oob_flag:
    assert property (err.dbu && !err.dau && !err.dsu && !oldUe
                     |=> st.stat[`DLC_S_DBU] && !st.stat[`DLC_S_DAU])
        else $error("out-of-bounds flag wrong");

    chk_flag_sticky:
    assert property (!wrStatus
                     |=> (st.stat & $past(st.stat)) == $past(st.stat))
        else $error("status flag cleared by hardware");

    chk_mixed_mec:
    assert property (ueNew && ceNew && !oldUe
                     |=> st.stat[`DLC_S_MEC]
                     && st.synd == $past(err.synd))
        else $error("mixed errors logged wrong");

    chk_no_wrap:
    assert property (!st.cntValid && !wrCount |=> $stable(st.count))
        else $error("count moved while disarmed");
endmodule

// >>> test/dlc_ecc_source.sv
`timescale 1ns/1ps
module dlc_ecc_source (
    input  wire logic          core_clk,
    input  wire logic          go,
    input  wire logic [4:0]    cls,
    input  wire logic [15:0]   synd,
    input  wire logic [35:0]   addr,
    input  wire logic [5:0]    nib,
    output dlc_pkg::dlc_err_t  err
);
    import dlc_pkg::*;
    initial err = '0;
    // Idle cycles show inverted data so stale fields never pass for a report
    always @(posedge core_clk) begin
        if (go) begin
            {err.dac, err.dau, err.dsc, err.dsu, err.dbu} <= cls;
            err.synd <= synd;
            err.addr <= addr;
            err.nibble <= nib;
        end else begin
            {err.dac, err.dau, err.dsc, err.dsu, err.dbu} <= 5'h0;
            err.synd <= ~err.synd;
            err.addr <= ~err.addr;
            err.nibble <= ~err.nibble;
        end
    end
endmodule

// >>> test/test_dram_error_log_counter.sv
`timescale 1ns/1ps
`include "dlc_defs.svh"
module test_dram_error_log_counter;
    import dlc_pkg::*;
    logic         core_clk;
    logic         sys_rst;
    dlc_bus_t     bus;
    logic [63:0]  rdData;
    dlc_err_t     err;
    logic         intMgmtLine;
    logic         trigClockStop;
    logic         trigErrPin;
    logic         irq;
    logic         go;
    logic [4:0]   cls;
    logic [15:0]  synd;
    logic [35:0]  eAddr;
    logic [5:0]   nib;
    int           miscompares = 0;
    int           comparisons = 0;
    // Four-state tallies so an unknown pulse shows up in the compare
    logic [31:0]  nMgmt = '0;
    logic [31:0]  nStop = '0;
    logic [31:0]  nPin = '0;

    dlc_error_log dlc_error_log_inst (.core_clk(core_clk), .sys_rst(sys_rst),
        .bus(bus), .rdData(rdData), .err(err), .intMgmtLine(intMgmtLine),
        .trigClockStop(trigClockStop), .trigErrPin(trigErrPin), .irq(irq));
    dlc_ecc_source dlc_ecc_source_inst (.core_clk(core_clk), .go(go),
        .cls(cls), .synd(synd), .addr(eAddr), .nib(nib), .err(err));

    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    // Pulses are only one cycle wide, so count them rather than sample them
    always @(posedge core_clk) begin
        nMgmt <= nMgmt + intMgmtLine;
        nStop <= nStop + trigClockStop;
        nPin <= nPin + trigErrPin;
    end

    task automatic chk(string name, logic [63:0] seen, logic [63:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(logic [11:0] a, logic [63:0] d);
        @(posedge core_clk);
        bus.wr <= 1'b1;
        bus.addr <= a;
        bus.wdata <= d;
        @(posedge core_clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rchk(string name, logic [11:0] a, logic [63:0] e);
        @(posedge core_clk);
        bus.rd <= 1'b1;
        bus.addr <= a;
        @(posedge core_clk);
        bus.rd <= 1'b0;
        @(negedge core_clk);
        chk(name, rdData, e);
    endtask
    function automatic logic [63:0] st(logic [6:0] f, logic [15:0] s);
        return {f, 41'h0, s};
    endfunction
    // Optional write lands on the same edge that takes the error report
    task automatic send(logic [4:0] c, logic [15:0] s, logic [35:0] a,
                        logic [5:0] n, logic w);
        @(posedge core_clk);
        go <= 1'b1;
        cls <= c;
        synd <= s;
        eAddr <= a;
        nib <= n;
        @(posedge core_clk);
        go <= 1'b0;
        bus.wr <= w;
        bus.addr <= `DLC_OFF_ADDR;
        bus.wdata <= 64'hFFFF_FFFF_FFFF_FFFF;
        @(posedge core_clk);
        bus.wr <= 1'b0;
        @(posedge core_clk);
        // Let the pulse tallies settle before anyone looks at them
        @(negedge core_clk);
    endtask
    task automatic clr;
        wr(`DLC_OFF_STATUS, 64'hFE00_0000_0000_0000);
    endtask

    task automatic t_regs;
        wr(`DLC_OFF_ADDR, 64'hFFFF_FFFF_FFFF_FFFF);
        rchk("address", `DLC_OFF_ADDR, 64'h0000_00FF_FFFF_FFF0);
        wr(`DLC_OFF_LOC, 64'hFFFF_FFFF_FFFF_FFFF);
        rchk("location", `DLC_OFF_LOC, 64'h0000_000F_FFFF_FFFF);
        wr(`DLC_OFF_COUNT, 64'hFFFF_FFFF_FFFF_FFFF);
        rchk("counter", `DLC_OFF_COUNT, 64'h3_FFFF);
        rchk("unmapped", 12'h290, 64'h0);
        $display("t_regs done");
    endtask
    task automatic t_count;
        wr(`DLC_OFF_IMASK, 64'h0);
        wr(`DLC_OFF_ISTAT, 64'h7);
        wr(`DLC_OFF_DBG, 64'h3);
        wr(`DLC_OFF_COUNT, 64'h3_0002);
        send(5'h04, 16'h1234, 36'h9_8765_4321, 6'h1F, 1'b0);
        rchk("count", `DLC_OFF_COUNT, 64'h3_0001);
        rchk("loc31", `DLC_OFF_LOC, 64'h8000_0000);
        rchk("scrubaddr", `DLC_OFF_ADDR, 64'h98_7654_3210);
        rchk("dsc", `DLC_OFF_STATUS, st(7'h04, 16'h1234));
        chk("irqmasked", irq, 64'h0);
        wr(`DLC_OFF_IMASK, 64'h4);
        @(negedge core_clk);
        chk("irq", irq, 64'h1);
        clr;
        send(5'h10, 16'h5555, 36'h1_1111_1111, 6'h21, 1'b0);
        rchk("zero", `DLC_OFF_COUNT, 64'h2_0000);
        chk("mgmt", nMgmt, 64'h1);
        chk("stop", nStop, 64'h1);
        chk("pin", nPin, 64'h0);
        rchk("dac", `DLC_OFF_STATUS, st(7'h10, 16'h5555));
        rchk("accaddr", `DLC_OFF_ADDR, 64'h98_7654_3210);
        rchk("loc33", `DLC_OFF_LOC, 64'h2_0000_0000);
        send(5'h10, 16'h5555, 36'h1_1111_1111, 6'h21, 1'b0);
        rchk("nowrap", `DLC_OFF_COUNT, 64'h2_0000);
        chk("mgmt2", nMgmt, 64'h1);
        rchk("istat", `DLC_OFF_ISTAT, 64'h5);
        wr(`DLC_OFF_ISTAT, 64'h7);
        @(negedge core_clk);
        chk("irqclr", irq, 64'h0);
        $display("t_count done");
    endtask
    task automatic t_ue;
        clr;
        wr(`DLC_OFF_COUNT, 64'h3_0005);
        wr(`DLC_OFF_DBG, 64'h1);
        send(5'h08, 16'hABCD, 36'h0_0000_0001, 6'h00, 1'b0);
        rchk("uecount", `DLC_OFF_COUNT, 64'h3_0005);
        rchk("dau", `DLC_OFF_STATUS, st(7'h08, 16'hABCD));
        chk("uemgmt", nMgmt, 64'h1);
        clr;
        send(5'h01, 16'h0001, 36'h0_0000_0002, 6'h00, 1'b0);
        rchk("dbu", `DLC_OFF_STATUS, st(7'h01, 16'h0001));
        clr;
        send(5'h12, 16'h7777, 36'hA_BCDE_F012, 6'h05, 1'b0);
        rchk("mixed", `DLC_OFF_STATUS, st(7'h22, 16'h7777));
        rchk("mixaddr", `DLC_OFF_ADDR, 64'hAB_CDEF_0120);
        wr(`DLC_OFF_STATUS, 64'h0400_0000_0000_0000);
        rchk("w1c", `DLC_OFF_STATUS, st(7'h20, 16'h0));
        wr(`DLC_OFF_COUNT, 64'h1_0001);
        send(5'h04, 16'h0002, 36'h0_0000_0003, 6'h00, 1'b0);
        chk("pintrig", nPin, 64'h1);
        chk("pinstop", nStop, 64'h1);
        $display("t_ue done");
    endtask
    task automatic t_race;
        // Clear flags first, else the report only raises mec
        clr;
        send(5'h04, 16'h0F0F, 36'h3_3333_3333, 6'h00, 1'b1);
        rchk("race", `DLC_OFF_ADDR, 64'h33_3333_3330);
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge core_clk);
        sys_rst <= 1'b0;
        rchk("keepaddr", `DLC_OFF_ADDR, 64'h33_3333_3330);
        rchk("keeploc", `DLC_OFF_LOC, 64'h1);
        rchk("keepcnt", `DLC_OFF_COUNT, 64'h0);
        $display("t_race done");
    endtask

    task automatic wrap_up;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    initial begin
        sys_rst = 1'b1;
        bus = '0;
        go = 1'b0;
        cls = '0;
        synd = '0;
        eAddr = '0;
        nib = '0;
        // Status is not reset, so clear it while reset still masks checks
        clr;
        sys_rst <= 1'b0;
        t_regs;
        t_count;
        t_ue;
        t_race;
        wrap_up;
    end
    initial begin
        #200000;
        miscompares++;
        wrap_up;
    end
endmodule
